// [verilog/sslp_pkg.sv]
// package: constants for sleep control and control-pin qualification
package sslp_pkg;
	localparam int SSLP_ADDR_W        = 17;
	localparam int SSLP_DATA_W        = 32;
	localparam int SSLP_BYTES         = 4;
	// sleep standby and recovery, in clock periods
	localparam int SSLP_SLEEP_STBY_PER = 2;
	localparam int SSLP_SLEEP_REC_PER  = 2;
	localparam int SSLP_CLK_NS         = 50;
	localparam int SSLP_SLEEP_REC_NS   = SSLP_SLEEP_REC_PER * SSLP_CLK_NS;
	localparam int SSLP_SLEEP_REC_CYC  = (SSLP_SLEEP_REC_NS + SSLP_CLK_NS - 1) / SSLP_CLK_NS;
	localparam int SSLP_SLEEP_STBY_CYC = SSLP_SLEEP_STBY_PER;
	localparam int SSLP_CNT_W         = 3;

	typedef enum logic [2:0] {
		SSLP_AWAKE  = 3'b001,
		SSLP_ASLEEP = 3'b010,
		SSLP_RECOV  = 3'b100
	} sslp_mode_e;
endpackage : sslp_pkg

// [verilog/sslp_array.sv]
// file: flip-flop storage array with byte write lanes
`timescale 1ns/1ps
module sslp_array
	import sslp_pkg::*;
#(
	parameter int ADDR_W = 4,
	parameter int DATA_W = SSLP_DATA_W,
	parameter int BYTES  = SSLP_BYTES
) (
	// clock
	input  wire logic              core_clk,
	// access
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [BYTES-1:0]  byteEn,
	input  wire logic [DATA_W-1:0] wrData,
	output logic      [DATA_W-1:0] rdData
);
	logic [DATA_W-1:0] mem [2**ADDR_W];

	// no reset: contents survive sleep and only change on an enabled lane
	always_ff @(posedge core_clk) begin
		for (int b = 0; b < BYTES; b++) begin
			if (byteEn[b]) begin
				mem[addr][b*8 +: 8] <= wrData[b*8 +: 8];
			end
		end
	end

	assign rdData = mem[addr];
endmodule : sslp_array

// [verilog/sslp_ctrl.sv]
// file: sleep entry/recovery control and control-pin qualification
// Overview of operation
// - sleep request powers down and deselects the device with no strobe command.
// - while asleep the internal clock enable is dropped, so state stays frozen except read data, which still reloads from the array.
// - while asleep all inputs but sleepRequest and burstOrderSelect are ignored; no select, no read, no write.
// - enabled only with first select low, second high, third low at a strobe.
// - write when global write low, or write enable low with a byte strobe.
// - output enable ignored once a write begins; controller drops it first.
`timescale 1ns/1ps
module sslp_ctrl
	import sslp_pkg::*;
#(
	parameter int ARRAY_ADDR_W = 4
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	// sleep
	input  wire logic                   sleepRequest,
	output logic                        sleepActive,
	output logic                        recoveryBusy,
	// address and burst control
	input  wire logic [SSLP_ADDR_W-1:0] addrIn,
	input  wire logic                   processorAddrStrobeN,
	input  wire logic                   controllerAddrStrobeN,
	input  wire logic                   burstAdvanceN,
	input  wire logic                   burstOrderSelect,
	// chip selects
	input  wire logic                   chipSelectFirstN,
	input  wire logic                   chipSelectSecond,
	input  wire logic                   chipSelectThirdN,
	// write strobes
	input  wire logic                   globalWriteN,
	input  wire logic                   writeEnableN,
	input  wire logic [SSLP_BYTES-1:0]  byteWriteN,
	// data bus, two-way
	input  wire logic                   outputEnableN,
	input  wire logic [SSLP_DATA_W-1:0] dataIn,
	output logic      [SSLP_DATA_W-1:0] dataOut,
	output logic                        dataOe,
	// status
	output logic                        selected,
	output logic                        writeCycle
);
	typedef struct packed {
		sslp_mode_e                  mode;
		logic [SSLP_CNT_W-1:0]       cnt;
		logic                        sel;
		logic                        wr;
		logic [SSLP_BYTES-1:0]       lanes;
		logic [SSLP_ADDR_W-1:0]      addr;
		logic [1:0]                  burstOfs;
		logic                        rdValid;
		logic [SSLP_DATA_W-1:0]      rdData;
	} sslp_state_s;

	sslp_state_s stQ;
	sslp_state_s stD;
	logic [SSLP_DATA_W-1:0] arrRd;
	logic [SSLP_BYTES-1:0]  arrEn;
	logic [SSLP_ADDR_W-1:0] curAddr;

	function automatic logic chip_enabled(input logic s1n, input logic s2, input logic s3n);
		return !s1n && s2 && !s3n;
	endfunction : chip_enabled

	function automatic logic [1:0] burst_addr(input logic [1:0] base, input logic [1:0] ofs,
			input logic interleave);
		return interleave ? (base ^ ofs) : 2'(base + ofs);
	endfunction : burst_addr

	// internal clock enable: dropped while asleep
	logic clkRun;
	assign clkRun = (stQ.mode != SSLP_ASLEEP) && !sleepRequest;

	always_comb begin
		logic anyStrobe;
		logic wrNow;
		stD = stQ;
		anyStrobe = !processorAddrStrobeN || !controllerAddrStrobeN;
		wrNow = !globalWriteN || (!writeEnableN && (byteWriteN != '1));
		// flow-through read data, registered for a clean output
		stD.rdData = arrRd;
		case (stQ.mode)
			SSLP_AWAKE: begin
				if (sleepRequest) begin
					stD.mode = SSLP_ASLEEP;
					stD.sel = 1'b0;
					stD.wr = 1'b0;
					stD.rdValid = 1'b0;
				end else if (anyStrobe) begin
					// processor strobe with first select high keeps the current state
					if (!processorAddrStrobeN && chipSelectFirstN) begin
						stD.sel = stQ.sel;
					end else begin
						stD.sel = chip_enabled(chipSelectFirstN, chipSelectSecond,
							chipSelectThirdN);
						stD.addr = addrIn;
						stD.burstOfs = 2'h0;
						stD.wr = 1'b0;
						stD.lanes = '0;
						// controller strobe samples the write strobes with the address
						if (processorAddrStrobeN && wrNow) begin
							stD.wr = 1'b1;
							stD.lanes = globalWriteN ? ~byteWriteN : '1;
						end
					end
				end else if (stQ.sel) begin
					stD.wr = wrNow;
					stD.lanes = !globalWriteN ? '1 : (writeEnableN ? '0 : ~byteWriteN);
					if (!burstAdvanceN) begin
						stD.burstOfs = 2'(stQ.burstOfs + 2'h1);
					end
				end
				stD.rdValid = stD.sel && !stD.wr && !sleepRequest;
			end
			SSLP_ASLEEP: begin
				// toggling inputs other than sleepRequest and burstOrderSelect have no effect here
				stD.sel = 1'b0;
				stD.wr = 1'b0;
				stD.rdValid = 1'b0;
				if (!sleepRequest) begin
					stD.mode = SSLP_RECOV;
					stD.cnt = SSLP_CNT_W'(SSLP_SLEEP_REC_CYC - 1);
				end
			end
			SSLP_RECOV: begin
				if (sleepRequest) begin
					stD.mode = SSLP_ASLEEP;
				end else if (stQ.cnt == '0) begin
					stD.mode = SSLP_AWAKE;
				end else begin
					stD.cnt = SSLP_CNT_W'(stQ.cnt - 1'b1);
				end
			end
			default: begin
				stD.mode = SSLP_AWAKE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stQ <= '{mode: SSLP_AWAKE, cnt: '0, sel: 1'b0, wr: 1'b0, lanes: '0,
				addr: '0, burstOfs: 2'h0, rdValid: 1'b0, rdData: '0};
		end else begin
			// always loads: sleep entry must land while the array enable is already gated
			// the asleep branch holds every field but rdData, standing in for the stopped clock
			stQ <= stD;
		end
	end

	assign curAddr = {stQ.addr[SSLP_ADDR_W-1:2],
		burst_addr(stQ.addr[1:0], stQ.burstOfs, burstOrderSelect)};
	// writes only while awake and selected; never in sleep
	assign arrEn = (stQ.mode == SSLP_AWAKE && stQ.sel && stQ.wr && clkRun) ? stQ.lanes : '0;

	sslp_array #(
		.ADDR_W (ARRAY_ADDR_W),
		.DATA_W (SSLP_DATA_W),
		.BYTES  (SSLP_BYTES)
	) uArray (
		.core_clk (core_clk),
		.addr     (curAddr[ARRAY_ADDR_W-1:0]),
		.byteEn   (arrEn),
		.wrData   (dataIn),
		.rdData   (arrRd)
	);

	assign dataOut      = stQ.rdData;
	// output enable has no say while a write is under way
	assign dataOe       = stQ.rdValid && !stQ.wr && !outputEnableN && !sleepRequest;
	assign sleepActive  = (stQ.mode == SSLP_ASLEEP);
	assign recoveryBusy = (stQ.mode == SSLP_RECOV);
	assign selected     = stQ.sel;
	assign writeCycle   = stQ.wr;
endmodule : sslp_ctrl

// [verification/sslp_ctrl_assertions.sv]
// checker: sleep entry, recovery and control-pin qualification
`timescale 1ns/1ps
module sslp_chk (
	input wire logic core_clk, rstn, sleepRequest, sleepActive, recoveryBusy, dataOe,
	input wire logic controllerAddrStrobeN, chipSelectFirstN, chipSelectSecond,
	input wire logic chipSelectThirdN, globalWriteN, writeEnableN, selected, writeCycle,
	input wire logic [3:0]  byteWriteN,
	input wire logic [31:0] dataOut
);
	wire e = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
	wire w = !globalWriteN || (!writeEnableN && byteWriteN != 4'hf);
	wire g = !sleepActive && !recoveryBusy && !sleepRequest && !controllerAddrStrobeN;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sleep_entry_a: assert property (
		sleepRequest && !sleepActive && !recoveryBusy |=> sleepActive && !selected)
		else $error("sleep not entered");
	clock_frozen_a: assert property (
		sleepActive && $past(sleepActive) |-> $stable(dataOut)) else $error("moved asleep");
	sleep_quiet_a: assert property (
		sleepActive || recoveryBusy |-> !selected && !writeCycle && !dataOe)
		else $error("active asleep");
	recovery_len_a: assert property (
		$rose(recoveryBusy) |=> recoveryBusy ##1 !recoveryBusy) else $error("recovery length");
	chip_enable_a: assert property (
		g |=> selected == $past(e)) else $error("enable decode");
	write_decode_a: assert property (
		g && e |=> writeCycle == $past(w)) else $error("write decode");
	oe_ignored_a: assert property (
		writeCycle |-> !dataOe) else $error("drive in write");
	cover property (g && e && w);
	cover property (sleepActive && !controllerAddrStrobeN);
	cover property ($rose(dataOe));
endmodule : sslp_chk
bind sslp_ctrl sslp_chk chk (.*);

// [verification/sslp_host_model.sv]
// partner: controller model driving strobes, selects and write data
`timescale 1ns/1ps
module sslp_host_model (
	input wire logic        core_clk,
	input wire logic [2:0]  op,
	input wire logic [3:0]  be,
	input wire logic [31:0] wd,
	output logic processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN, burstOrderSelect,
	output logic chipSelectFirstN, chipSelectSecond, chipSelectThirdN, outputEnableN,
	output logic globalWriteN, writeEnableN,
	output logic [3:0]  byteWriteN,
	output logic [31:0] dataIn
);
	// ops: 1 read, 2 write, 3 output on, 4 byte write, 5 deselected read
	logic        hold_q = 1'b0;
	logic [31:0] last_q = 32'h0;
	wire w = op == 3'h2 || op == 3'h4;
	always_ff @(posedge core_clk) begin
		hold_q <= w;
		if (w)
			last_q <= wd;
	end
	// released bus holds the last write data for one cycle, then shows its inverse
	assign dataIn = w ? wd : hold_q ? last_q : ~last_q;
	assign {processorAddrStrobeN, burstAdvanceN, burstOrderSelect} = 3'h6;
	assign controllerAddrStrobeN = op == 3'h0 || op == 3'h3;
	assign {chipSelectFirstN, chipSelectSecond, chipSelectThirdN} = {op == 3'h5, 2'h2};
	assign globalWriteN = op != 3'h2;
	assign writeEnableN = op != 3'h4;
	assign byteWriteN = writeEnableN ? 4'hf : ~be;
	assign outputEnableN = op != 3'h3;
endmodule : sslp_host_model

// [verification/tb_sslp_ctrl.sv]
// testbench: sleep control and control-pin qualification
`timescale 1ns/1ps
module tb_sslp_ctrl import sslp_pkg::*; ;
	logic core_clk = 1'b0, rstn = 1'b0, sleepRequest = 1'b0;
	logic [2:0] op = 3'h0;
	logic [3:0] be = 4'h0, byteWriteN, a;
	logic [1:0] oeH = 2'h0;
	logic [SSLP_ADDR_W-1:0] addrIn = 17'h0;
	logic [SSLP_DATA_W-1:0] wd = 32'h0, dataIn, dataOut, mem [16], q [$];
	logic processorAddrStrobeN, controllerAddrStrobeN, burstAdvanceN, burstOrderSelect;
	logic chipSelectFirstN, chipSelectSecond, chipSelectThirdN, outputEnableN, globalWriteN;
	logic writeEnableN, sleepActive, recoveryBusy, dataOe, selected, writeCycle;
	int nFail, checksDone, cyc;
	sslp_ctrl dut (.*);
	sslp_host_model host (.*);
	initial forever #25 core_clk = ~core_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic cmp(input string s, input logic [31:0] e, g);
		checksDone++;
		if (g !== e) begin
			nFail++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic final_report();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// one strobe, then output-on cycles for reads; upper address bits are noise
	task automatic acc(input logic [2:0] o, input logic [3:0] x, input logic [31:0] d,
			input logic [3:0] m);
		op <= o;
		addrIn <= {13'($urandom), x};
		wd <= d;
		be <= m;
		if (o == 3'h1)
			q.push_back(mem[x]);
		tick(1);
		op <= o[0] ? 3'h3 : 3'h0;
		tick(2);
		op <= 3'h0;
		tick(1);
		for (int b = 0; b < 4; b++)
			if ((o == 3'h2 || o == 3'h4 && m[b]) && !sleepRequest)
				mem[x][8*b+:8] = d[8*b+:8];
	endtask : acc
	always @(negedge core_clk) begin
		oeH <= {oeH[0], dataOe};
		// data driven once sleep is requested may be stale, so it is never compared
		if (oeH === 2'b01 && dataOe === 1'b1 && sleepRequest === 1'b0)
			cmp("read data", q.pop_front(), dataOut);
		if (++cyc == 1000) begin
			nFail++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'hc18ef621));
		tick(6);
		rstn <= 1'b1;
		for (int i = 0; i < 16; i++)
			acc(3'h2, 4'(i), $urandom, 4'hf);
		repeat (12) begin
			a = 4'($urandom);
			acc(3'h4, a, $urandom, 4'($urandom));
			acc(3'h1, a, 32'h0, 4'h0);
		end
		$display("test read write done");
		acc(3'h5, a, 32'h0, 4'h0);
		acc(3'h1, a, 32'h0, 4'h0);
		$display("test deselect done");
		sleepRequest <= 1'b1;
		tick(2);
		repeat (3)
			acc(3'h2, a, $urandom, 4'hf);
		sleepRequest <= 1'b0;
		tick(4);
		acc(3'h1, a, 32'h0, 4'h0);
		$display("test sleep done");
		cmp("pending reads", 32'h0, 32'(q.size()));
		final_report();
	end
endmodule : tb_sslp_ctrl
